// ===== shared/afscr_consts.svh
`ifndef AFSCR_CONSTS_SVH
`define AFSCR_CONSTS_SVH

// ****************************************
// Control-port register offsets
// ****************************************
`define AFSCR_OFS_FAULT 8'h08
`define AFSCR_OFS_RSV_FIRST 8'h09
`define AFSCR_OFS_RSV_LAST 8'h0F
`define AFSCR_OFS_CLIP_MID 8'h10
`define AFSCR_OFS_CLIP_LOW 8'h11

// ****************************************
// Fault register field positions
// ****************************************
`define AFSCR_FLT_RSV_MSB 7
`define AFSCR_FLT_RSV_LSB 6
`define AFSCR_FLT_TRIP_MSB 5
`define AFSCR_FLT_TRIP_LSB 4
`define AFSCR_FLT_CLK_BIT 3
`define AFSCR_FLT_OC_BIT 2
`define AFSCR_FLT_DC_BIT 1
`define AFSCR_FLT_OT_BIT 0

// ****************************************
// Clip register field positions
// ****************************************
`define AFSCR_CLIP_LOW_MSB 7
`define AFSCR_CLIP_LOW_LSB 2

// ****************************************
// Reset values
// ****************************************
`define AFSCR_RST_TRIP 2'h0
`define AFSCR_RST_CLIP_MID 8'h01
`define AFSCR_RST_CLIP_LOW 8'h04
`define AFSCR_RST_RSV 2'h0

// ****************************************
// Trip level codes and scale in percent
// ****************************************
`define AFSCR_TRIP_100 2'h0
`define AFSCR_TRIP_75 2'h1
`define AFSCR_TRIP_50 2'h2
`define AFSCR_TRIP_25 2'h3
`define AFSCR_PCT_100 7'h64
`define AFSCR_PCT_75 7'h4B
`define AFSCR_PCT_50 7'h32
`define AFSCR_PCT_25 7'h19

// ****************************************
// Serial control port
// ****************************************
// Arbitrary default target address
`define AFSCR_DEV_ADDR 7'h2A
`define AFSCR_BITS_PER_BYTE 4'h8

`endif

// ===== shared/afscr_pkg.sv
package afscr_pkg;

  // ****************************************
  // Fault condition group
  // ****************************************
  typedef struct packed {
    logic clock;
    logic overcurrent;
    logic output_offset;
    logic overtemp;
  } afscr_fault_t;

  // ****************************************
  // Control port states
  // ****************************************
  typedef enum logic [3:0] {
    AFSCR_IDLE,
    AFSCR_ADDR,
    AFSCR_ACK_ADDR,
    AFSCR_REG,
    AFSCR_ACK_REG,
    AFSCR_WRITE,
    AFSCR_ACK_WR,
    AFSCR_RD_LOAD,
    AFSCR_READ,
    AFSCR_RD_ACK
  } afscr_state_t;

endpackage : afscr_pkg

// ===== core/afscr_fault_latch.sv
`timescale 1ns/100ps

// ****************************************
// Sticky fault flag
// ****************************************
module afscr_fault_latch (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic detect,
  input wire logic release_pulse,
  output logic flag
);

  // A live fault beats the release, so nothing is lost on the exit edge
  logic next_flag;
  assign next_flag = detect ? 1'b1 : (release_pulse ? 1'b0 : flag);

  // Flag register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      flag <= 1'b0;
    end else begin
      flag <= next_flag;
    end
  end

endmodule : afscr_fault_latch

// ===== core/afscr_regs.sv
`timescale 1ns/100ps
`include "afscr_consts.svh"


module afscr_regs #(
  parameter logic [6:0] DEV_ADDR = `AFSCR_DEV_ADDR
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic speaker_shutdown_n,
  input wire logic ctrl_shutdown_n,
  input wire afscr_pkg::afscr_fault_t fault_det,
  input wire logic [5:0] clip_level_upper,
  output logic [1:0] overcurrent_trip_level_sel,
  output logic [6:0] trip_level_pct,
  output logic [19:0] clip_threshold_level,
  output afscr_pkg::afscr_fault_t fault_status,
  output logic fault_halt,
  output logic shutdown_active
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // Scale of the overcurrent trip level for a code
  function automatic logic [6:0] afscr_trip_pct(input logic [1:0] code);
    logic [6:0] pct;
    case (code)
      `AFSCR_TRIP_75: pct = `AFSCR_PCT_75;
      `AFSCR_TRIP_50: pct = `AFSCR_PCT_50;
      `AFSCR_TRIP_25: pct = `AFSCR_PCT_25;
      default: pct = `AFSCR_PCT_100;
    endcase
    return pct;
  endfunction : afscr_trip_pct

  // Hit on one register offset
  function automatic logic afscr_hit(input logic [7:0] ptr_v, input logic [7:0] ofs);
    return ptr_v == ofs;
  endfunction : afscr_hit

  // ****************************************
  // Serial control port
  // ****************************************
  afscr_pkg::afscr_state_t st;
  afscr_pkg::afscr_state_t next_st;
  logic scl_q;
  logic sda_q;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] ptr;
  logic [7:0] next_ptr;
  logic rw;
  logic next_rw;
  logic next_oe;
  logic wr_en;
  logic [7:0] rdata;
  logic byte_done;

  // Bus conditions; pins are already synchronous to ref_clk
  wire scl_rise = scl & ~scl_q;
  wire scl_fall = ~scl & scl_q;
  wire bus_start = scl & scl_q & sda_q & ~sda_in;
  wire bus_stop = scl & scl_q & ~sda_q & sda_in;
  assign byte_done = (cnt == `AFSCR_BITS_PER_BYTE);

  // Sampled pin copies for edge detection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda_in;
    end
  end

  // Port sequencing: sample on SCL rise, change SDA on SCL fall
  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_shift = shift;
    next_ptr = ptr;
    next_rw = rw;
    next_oe = sda_oe;
    wr_en = 1'b0;
    if (bus_start) begin
      next_st = afscr_pkg::AFSCR_ADDR;
      next_cnt = 4'h0;
      next_oe = 1'b0;
    end else if (bus_stop) begin
      next_st = afscr_pkg::AFSCR_IDLE;
      next_oe = 1'b0;
    end else if (scl_rise) begin
      case (st)
        afscr_pkg::AFSCR_ADDR, afscr_pkg::AFSCR_REG, afscr_pkg::AFSCR_WRITE: begin
          next_shift = {shift[6:0], sda_in};
          next_cnt = 4'(cnt + 4'h1);
        end
        afscr_pkg::AFSCR_READ: begin
          next_cnt = 4'(cnt + 4'h1);
        end
        afscr_pkg::AFSCR_RD_ACK: begin
          // A not-acknowledge ends the read burst
          next_st = sda_in ? afscr_pkg::AFSCR_IDLE : afscr_pkg::AFSCR_RD_LOAD;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st)
        afscr_pkg::AFSCR_ADDR: begin
          if (byte_done && shift[7:1] == DEV_ADDR) begin
            next_st = afscr_pkg::AFSCR_ACK_ADDR;
            next_rw = shift[0];
            next_oe = 1'b1;
          end else if (byte_done) begin
            next_st = afscr_pkg::AFSCR_IDLE;
          end
        end
        afscr_pkg::AFSCR_REG: begin
          if (byte_done) begin
            next_ptr = shift;
            next_oe = 1'b1;
            next_st = afscr_pkg::AFSCR_ACK_REG;
          end
        end
        afscr_pkg::AFSCR_WRITE: begin
          if (byte_done) begin
            wr_en = 1'b1;
            next_ptr = 8'(ptr + 8'h01);
            next_oe = 1'b1;
            next_st = afscr_pkg::AFSCR_ACK_WR;
          end
        end
        afscr_pkg::AFSCR_ACK_ADDR: begin
          next_cnt = 4'h0;
          if (rw) begin
            next_shift = rdata;
            next_oe = ~rdata[7];
            next_ptr = 8'(ptr + 8'h01);
            next_st = afscr_pkg::AFSCR_READ;
          end else begin
            next_oe = 1'b0;
            next_st = afscr_pkg::AFSCR_REG;
          end
        end
        afscr_pkg::AFSCR_ACK_REG, afscr_pkg::AFSCR_ACK_WR: begin
          next_oe = 1'b0;
          next_cnt = 4'h0;
          next_st = afscr_pkg::AFSCR_WRITE;
        end
        afscr_pkg::AFSCR_RD_LOAD: begin
          next_cnt = 4'h0;
          next_shift = rdata;
          next_oe = ~rdata[7];
          next_ptr = 8'(ptr + 8'h01);
          next_st = afscr_pkg::AFSCR_READ;
        end
        afscr_pkg::AFSCR_READ: begin
          if (byte_done) begin
            next_oe = 1'b0;
            next_st = afscr_pkg::AFSCR_RD_ACK;
          end else begin
            next_shift = {shift[6:0], 1'b0};
            next_oe = ~shift[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Port state registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= afscr_pkg::AFSCR_IDLE;
      cnt <= 4'h0;
      shift <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      shift <= next_shift;
      ptr <= next_ptr;
      rw <= next_rw;
      sda_oe <= next_oe;
      sda_out <= 1'b0;
    end
  end

  // ****************************************
  // Register file
  // ****************************************
  logic [1:0] trip_sel;
  logic [7:0] clip_mid;
  logic [7:0] clip_low;
  logic clk_flag;
  logic [2:0] latched;

  // Write decode; unmapped and reserved offsets swallow the data
  wire wr_fault = wr_en & afscr_hit(ptr, `AFSCR_OFS_FAULT);
  wire wr_mid = wr_en & afscr_hit(ptr, `AFSCR_OFS_CLIP_MID);
  wire wr_low = wr_en & afscr_hit(ptr, `AFSCR_OFS_CLIP_LOW);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      trip_sel <= `AFSCR_RST_TRIP;
    end else if (wr_fault) begin
      trip_sel <= shift[`AFSCR_FLT_TRIP_MSB:`AFSCR_FLT_TRIP_LSB];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clip_mid <= `AFSCR_RST_CLIP_MID;
      clip_low <= `AFSCR_RST_CLIP_LOW;
    end else begin
      if (wr_mid) begin
        clip_mid <= shift;
      end
      if (wr_low) begin
        clip_low <= shift;
      end
    end
  end

  // Fault byte as read back
  wire [7:0] fault_byte = {`AFSCR_RST_RSV, trip_sel, clk_flag, latched};

  assign rdata = afscr_hit(ptr, `AFSCR_OFS_FAULT) ? fault_byte :
                 afscr_hit(ptr, `AFSCR_OFS_CLIP_MID) ? clip_mid :
                 afscr_hit(ptr, `AFSCR_OFS_CLIP_LOW) ? clip_low : 8'h00;

  // ****************************************
  // Shutdown and fault flags
  // ****************************************
  logic sd_q;

  wire sd_now = ~speaker_shutdown_n | ~ctrl_shutdown_n;

  wire release_pulse = sd_q & ~sd_now;

  // Previous shutdown state for the exit edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sd_q <= 1'b0;
    end else begin
      sd_q <= sd_now;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_flag <= 1'b0;
    end else begin
      clk_flag <= fault_det.clock;
    end
  end

  // Latching faults in bit order overcurrent, offset, temperature
  wire [2:0] sticky_det = {fault_det.overcurrent, fault_det.output_offset, fault_det.overtemp};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_latch
      afscr_fault_latch u_latch (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .detect(sticky_det[g]),
        .release_pulse(release_pulse),
        .flag(latched[g])
      );
    end
  endgenerate

  // ****************************************
  // Registered outputs
  // ****************************************

  // One cycle behind the flags; fine for a halt that lasts milliseconds
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      overcurrent_trip_level_sel <= `AFSCR_RST_TRIP;
      trip_level_pct <= `AFSCR_PCT_100;
      clip_threshold_level <= 20'h00000;
      fault_status <= '0;
      fault_halt <= 1'b0;
      shutdown_active <= 1'b0;
    end else begin
      overcurrent_trip_level_sel <= trip_sel;
      trip_level_pct <= afscr_trip_pct(trip_sel);
      clip_threshold_level <= {clip_level_upper, clip_mid,
                               clip_low[`AFSCR_CLIP_LOW_MSB:`AFSCR_CLIP_LOW_LSB]};
      fault_status <= {clk_flag, latched};
      fault_halt <= clk_flag | (|latched);
      shutdown_active <= sd_now;
    end
  end

endmodule : afscr_regs

// ===== testbench/afscr_regs_checker.sv
`timescale 1ns/100ps
// ****************************************
// Port checker
// ****************************************
module afscr_regs_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic speaker_shutdown_n,
  input wire logic ctrl_shutdown_n,
  input wire afscr_pkg::afscr_fault_t fault_det,
  input wire logic [5:0] clip_level_upper,
  input wire logic [1:0] overcurrent_trip_level_sel,
  input wire logic [6:0] trip_level_pct,
  input wire logic [19:0] clip_threshold_level,
  input wire afscr_pkg::afscr_fault_t fault_status,
  input wire logic fault_halt,
  input wire logic shutdown_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Both shutdown controls released
  wire run_ok = speaker_shutdown_n & ctrl_shutdown_n;
  // Shutdown left
  sequence s_sd_exit;
    !run_ok ##1 run_ok;
  endsequence
  property p_clk_follow;
    $past(rstn) && $past(rstn, 2) |-> fault_status.clock == $past(fault_det.clock, 2);
  endproperty
  property p_oc_set;
    fault_det.overcurrent |-> ##2 fault_status.overcurrent;
  endproperty
  property p_oc_hold;
    $fell(fault_status.overcurrent) |-> $past(run_ok, 2) && !$past(run_ok, 3);
  endproperty
  property p_oc_clear;
    s_sd_exit ##0 !fault_det.overcurrent ##1 !fault_det.overcurrent
      |-> ##1 !fault_status.overcurrent;
  endproperty
  property p_dc_hold;
    $fell(fault_status.output_offset) |-> $past(run_ok, 2) && !$past(run_ok, 3);
  endproperty
  property p_ot_clear;
    s_sd_exit ##0 !fault_det.overtemp ##1 !fault_det.overtemp |-> ##1 !fault_status.overtemp;
  endproperty
  property p_trip_pct;
    trip_level_pct == (overcurrent_trip_level_sel == 2'h0 ? 7'h64 :
      overcurrent_trip_level_sel == 2'h1 ? 7'h4B :
      overcurrent_trip_level_sel == 2'h2 ? 7'h32 : 7'h19);
  endproperty
  property p_halt_or;
    fault_halt == |fault_status;
  endproperty
  property p_clip_join;
    $past(rstn) && $past(rstn, 2) |-> clip_threshold_level[19:14] == $past(clip_level_upper);
  endproperty
  property p_sd_state;
    $past(rstn) |-> shutdown_active == !$past(run_ok);
  endproperty
  a_clk_follow: assert property (p_clk_follow) else $error("clock flag not following");
  a_oc_set: assert property (p_oc_set) else $error("overcurrent flag not set");
  a_oc_hold: assert property (p_oc_hold) else $error("overcurrent flag dropped");
  a_oc_clear: assert property (p_oc_clear) else $error("overcurrent flag kept");
  a_dc_hold: assert property (p_dc_hold) else $error("offset flag dropped");
  a_ot_clear: assert property (p_ot_clear) else $error("overtemp flag kept");
  a_trip_pct: assert property (p_trip_pct) else $error("trip percent wrong");
  a_halt_or: assert property (p_halt_or) else $error("halt not fault OR");
  a_clip_join: assert property (p_clip_join) else $error("clip upper slice wrong");
  a_sd_state: assert property (p_sd_state) else $error("shutdown state wrong");
endmodule : afscr_regs_checker

bind afscr_regs afscr_regs_checker u_chk (.ref_clk, .rstn, .speaker_shutdown_n,
  .ctrl_shutdown_n, .fault_det, .clip_level_upper, .overcurrent_trip_level_sel,
  .trip_level_pct, .clip_threshold_level, .fault_status, .fault_halt, .shutdown_active);

// ===== testbench/afscr_host_model.sv
`timescale 1ns/100ps
// ****************************************
// Control port master
// ****************************************
module afscr_host_model (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  logic [7:0] q;
  logic ack_seen;
  // Idle bus, both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Four cycles per phase, above the three cycle minimum
  task automatic ph();
    repeat (4) @(posedge ref_clk);
  endtask : ph
  task automatic start();
    sda_low <= 1'b0;
    ph();
    scl <= 1'b1;
    ph();
    sda_low <= 1'b1;
    ph();
    scl <= 1'b0;
    ph();
  endtask : start
  task automatic stop();
    sda_low <= 1'b1;
    ph();
    scl <= 1'b1;
    ph();
    sda_low <= 1'b0;
    ph();
  endtask : stop
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic last);
    for (int i = 8; i >= 0; i--) begin
      sda_low <= (i > 0) ? ~d[i-1] : ~last;
      ph();
      scl <= 1'b1;
      ph();
      if (i > 0) q[i-1] = sda_line;
      else ack_seen = ~sda_line;
      scl <= 1'b0;
      ph();
    end
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    start();
    xfer(8'h54, 1'b1);
    ok = ack_seen;
    xfer(a, 1'b1);
    ok &= ack_seen;
    xfer(d, 1'b1);
    ok &= ack_seen;
    stop();
  endtask : wr
  // Single byte read, ended by a NACK
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start();
    xfer(8'h54, 1'b1);
    xfer(a, 1'b1);
    start();
    xfer(8'h55, 1'b1);
    xfer(8'hFF, 1'b1);
    d = q;
    stop();
  endtask : rd
  // Foreign target address: the acknowledge slot must stay released
  task automatic probe(input logic [7:0] b, output logic ok);
    start();
    xfer(b, 1'b1);
    ok = ack_seen;
    stop();
  endtask : probe
  // Two data bytes in one frame; the pointer steps on by itself
  task automatic wr2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1,
                     output logic ok);
    start();
    xfer(8'h54, 1'b1);
    ok = ack_seen;
    xfer(a, 1'b1);
    ok &= ack_seen;
    xfer(d0, 1'b1);
    ok &= ack_seen;
    xfer(d1, 1'b1);
    ok &= ack_seen;
    stop();
  endtask : wr2
  // Two bytes read in one frame, the first acknowledged by the host
  task automatic rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
    start();
    xfer(8'h54, 1'b1);
    xfer(a, 1'b1);
    start();
    xfer(8'h55, 1'b1);
    xfer(8'hFF, 1'b0);
    d0 = q;
    xfer(8'hFF, 1'b1);
    d1 = q;
    stop();
  endtask : rd2
endmodule : afscr_host_model

// ===== testbench/testbench.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("unexpected %s exp %h got %h", nm, (e), (g)); \
  end \
end
// ****************************************
// Testbench top
// ****************************************
module testbench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic speaker_shutdown_n = 1'b1;
  logic ctrl_shutdown_n = 1'b1;
  afscr_pkg::afscr_fault_t fault_det = '0;
  afscr_pkg::afscr_fault_t fault_status;
  logic [5:0] clip_level_upper = 6'h00;
  logic [1:0] overcurrent_trip_level_sel;
  logic [6:0] trip_level_pct;
  logic [19:0] clip_threshold_level;
  logic scl, sda_in, sda_out, sda_oe, sda_low, fault_halt, shutdown_active, ok;
  logic [7:0] rv, rv2, mid, low;
  int err_total = 0;
  int cmp_count = 0;
  always #25 ref_clk = ~ref_clk;
  // Pulled up unless someone pulls low
  assign sda_in = ~(sda_low | sda_oe);
  afscr_regs dut (.ref_clk, .rstn, .scl, .sda_in, .sda_out, .sda_oe, .speaker_shutdown_n,
    .ctrl_shutdown_n, .fault_det, .clip_level_upper, .overcurrent_trip_level_sel,
    .trip_level_pct, .clip_threshold_level, .fault_status, .fault_halt, .shutdown_active);
  afscr_host_model host (.ref_clk, .sda_line(sda_in), .scl, .sda_low);
  function automatic logic [6:0] pct_of(input logic [1:0] c);
    return c == 2'h0 ? 7'h64 : c == 2'h1 ? 7'h4B : c == 2'h2 ? 7'h32 : 7'h19;
  endfunction : pct_of
  function automatic logic [19:0] clip_of(input logic [5:0] u, input logic [7:0] m, l);
    return {u, m, l[7:2]};
  endfunction : clip_of
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, ok);
    `CHK("ack", 1'b1, ok)
  endtask : wreg
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv);
    `CHK("reg", e, rv)
  endtask : chk_reg
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  // Hang guard, far beyond the expected run
  initial begin
    #2000000;
    err_total++;
    final_report();
  end
  // Main sequence; only mapped offsets are touched
  initial begin
    void'($urandom(32'h38232B12));
    tick(10);
    rstn <= 1'b1;
    tick(3);
    `CHK("trip", 2'h0, overcurrent_trip_level_sel)
    chk_reg(8'h08, 8'h00);
    chk_reg(8'h10, 8'h01);
    chk_reg(8'h11, 8'h04);
    speaker_shutdown_n <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wreg(8'h08, {2'h0, c[1:0], 4'($urandom)});
      chk_reg(8'h08, {2'h0, c[1:0], 4'h0});
      `CHK("pct", pct_of(c[1:0]), trip_level_pct)
      `CHK("trip", c[1:0], overcurrent_trip_level_sel)
    end
    for (int k = 0; k < 3; k++) begin
      mid = k ? 8'($urandom) : 8'hFF;
      low = k ? {6'($urandom), 2'h0} : 8'hFC;
      clip_level_upper <= k ? 6'($urandom) : 6'h3F;
      wreg(8'h10, mid);
      wreg(8'h11, low);
      `CHK("clip", clip_of(clip_level_upper, mid, low), clip_threshold_level)
      chk_reg(8'h11, low);
    end
    // Burst write and burst read exercise pointer stepping and host acknowledge
    mid = 8'($urandom);
    low = {6'($urandom), 2'h0};
    host.wr2(8'h10, mid, low, ok);
    `CHK("ack2", 1'b1, ok)
    host.rd2(8'h10, rv, rv2);
    `CHK("mid2", mid, rv)
    `CHK("low2", low, rv2)
    `CHK("clip2", clip_of(clip_level_upper, mid, low), clip_threshold_level)
    // Foreign address is left unanswered, data pin stays open drain
    host.probe(8'h56, ok);
    `CHK("nack", 1'b0, ok)
    `CHK("sda_out", 1'b0, sda_out)
    speaker_shutdown_n <= 1'b1;
    fault_det.clock <= 1'b1;
    chk_reg(8'h08, 8'h38);
    fault_det.clock <= 1'b0;
    tick(3);
    `CHK("clk", 1'b0, fault_status.clock)
    // Latched flags; overtemp keeps its detector high through the first exit
    for (int b = 0; b < 3; b++) begin
      fault_det[b] <= 1'b1;
      tick(1);
      fault_det[b] <= 1'b0;
      tick(4);
      `CHK("set", 1'b1, fault_status[b])
      `CHK("halt", 1'b1, fault_halt)
      if (b == 1) ctrl_shutdown_n <= 1'b0;
      else speaker_shutdown_n <= 1'b0;
      fault_det[b] <= (b == 0);
      tick(4);
      `CHK("hold", 1'b1, fault_status[b])
      `CHK("sd", 1'b1, shutdown_active)
      speaker_shutdown_n <= 1'b1;
      ctrl_shutdown_n <= 1'b1;
      tick(4);
      `CHK("exit", (b == 0), fault_status[b])
      fault_det[b] <= 1'b0;
      speaker_shutdown_n <= 1'b0;
      tick(2);
      speaker_shutdown_n <= 1'b1;
      tick(4);
      `CHK("clear", 1'b0, fault_status[b])
      `CHK("halt", 1'b0, fault_halt)
      `CHK("sd", 1'b0, shutdown_active)
    end
    rstn <= 1'b0;
    tick(2);
    rstn <= 1'b1;
    tick(3);
    `CHK("trip", 2'h0, overcurrent_trip_level_sel)
    final_report();
  end
endmodule : testbench
